// ### gpwm_engine.v
// Grayscale PWM engine top: APB registers, grayscale counter, 16 channel sinks.
// Assumes grayscale_clock is an asynchronous pin slower than clk_sys / 2.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpwm_consts.vh"
module gpwm_engine #(
  parameter CHANNELS = 16
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire grayscale_clock,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire [CHANNELS-1:0] sink_output_n
);
  // Control bits, first stage
  reg blank_r;
  reg spread_first_r;
  reg timing_reset_bit_r;
  reg auto_repeat_bit_r;

  // Second stage mode bit
  reg spread_second_r;

  // Grayscale latches
  reg [15:0] gs_first_r [0:CHANNELS-1];
  reg [15:0] gs_second_r [0:CHANNELS-1];

  // Display timing
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg active_r;
  reg active_nxt;
  reg armed_r;
  reg armed_nxt;

  // Outputs
  reg [CHANNELS-1:0] sink_r;
  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;

  wire gs_rise;
  wire [15:0] pos;
  wire [CHANNELS-1:0] lit;
  wire setup_ph;
  wire wr_take;
  wire ctrl_hit;
  wire latch_hit;
  wire status_hit;
  wire sink_hit;
  wire gs_hit;
  wire [3:0] gs_idx;
  wire latch_strobe;
  wire tmg_pulse;
  wire period_end;
  wire rpt_pulse;
  wire restart;

  integer k;

  // Grayscale clock edge in the system domain
  gpwm_sync u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in(grayscale_clock),
    .rise(gs_rise)
  );

  // APB decode
  assign setup_ph = psel & ~penable;
  assign wr_take = psel & penable & pready_r & pwrite;
  assign ctrl_hit = (paddr == `GPWM_CTRL_OFS);
  assign latch_hit = (paddr == `GPWM_LATCH_OFS);
  assign status_hit = (paddr == `GPWM_STATUS_OFS);
  assign sink_hit = (paddr == `GPWM_SINK_OFS);
  assign gs_hit = (paddr >= `GPWM_GS_BASE_OFS) && (paddr <= `GPWM_GS_LAST_OFS) &&
                  (paddr[1:0] == 2'b00);
  assign gs_idx = paddr[5:2];
  assign latch_strobe = wr_take & latch_hit & ~pslverr_r;

  // Period end, and the pulses that behave as a momentary blank
  assign tmg_pulse = latch_strobe & timing_reset_bit_r;
  assign period_end = gs_rise & active_r & (pos == (`GPWM_LAST_POS - 16'h0001));
  assign rpt_pulse = period_end & auto_repeat_bit_r;
  assign restart = tmg_pulse | rpt_pulse;

  // Clocks elapsed inside the period
  assign pos = cnt_r - 16'h0001;

  // APB slave: one wait-free access phase, registered answer
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      if (setup_ph) begin
        pready_r <= 1'b1;
        pslverr_r <= ~(ctrl_hit | latch_hit | status_hit | sink_hit | gs_hit);
        prdata_r <= 32'h00000000;
        if (!pwrite) begin
          if (ctrl_hit) begin
            prdata_r <= {28'h0000000, auto_repeat_bit_r, timing_reset_bit_r,
                         spread_first_r, blank_r};
          end else if (status_hit) begin
            prdata_r <= {14'h0000, armed_r, active_r, cnt_r};
          end else if (sink_hit) begin
            prdata_r <= {16'h0000, sink_r};
          end else if (gs_hit) begin
            prdata_r <= {16'h0000, gs_first_r[gs_idx]};
          end
        end
      end else begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
      end
    end
  end

  // Control register
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      blank_r <= 1'b1;
      spread_first_r <= 1'b0;
      timing_reset_bit_r <= 1'b0;
      auto_repeat_bit_r <= 1'b0;
    end else if (wr_take & ctrl_hit) begin
      blank_r <= pwdata[`GPWM_CTRL_BLANK];
      spread_first_r <= pwdata[`GPWM_CTRL_SPREAD];
      timing_reset_bit_r <= pwdata[`GPWM_CTRL_TIMING_RESET_BIT];
      auto_repeat_bit_r <= pwdata[`GPWM_CTRL_REPEAT];
    end
  end

  // First and second grayscale latches
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      spread_second_r <= 1'b0;
      for (k = 0; k < CHANNELS; k = k + 1) begin
        gs_first_r[k] <= `GPWM_GS_RST;
        gs_second_r[k] <= `GPWM_GS_RST;
      end
    end else begin
      if (wr_take & gs_hit) begin
        gs_first_r[gs_idx] <= pwdata[15:0];
      end
      if (latch_strobe) begin
        spread_second_r <= spread_first_r;
        for (k = 0; k < CHANNELS; k = k + 1) begin
          gs_second_r[k] <= gs_first_r[k];
        end
      end
    end
  end

  // Counter and period state
  always @* begin
    cnt_nxt = cnt_r;
    active_nxt = active_r;
    armed_nxt = armed_r;
    if (blank_r) begin
      cnt_nxt = `GPWM_CNT_RST;
      active_nxt = 1'b0;
      armed_nxt = 1'b1;
    end else if (restart) begin
      cnt_nxt = `GPWM_CNT_RST;
      active_nxt = 1'b0;
      armed_nxt = 1'b1;
    end else if (period_end) begin
      cnt_nxt = `GPWM_CNT_RST;
      active_nxt = 1'b0;
      armed_nxt = 1'b0;
    end else if (gs_rise) begin
      if (active_r) begin
        cnt_nxt = cnt_r + 16'h0001;
      end else if (armed_r) begin
        cnt_nxt = 16'h0001;
        active_nxt = 1'b1;
        armed_nxt = 1'b0;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= `GPWM_CNT_RST;
      active_r <= 1'b0;
      armed_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      active_r <= active_nxt;
      armed_r <= armed_nxt;
    end
  end

  // Channel comparators
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
      gpwm_chan u_chan (
        .gs_value(gs_second_r[g]),
        .pos(pos),
        .spread_sel(spread_second_r),
        .active(active_r),
        .lit(lit[g])
      );
    end
  endgenerate

  // Sink drive, low while conducting
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sink_r <= `GPWM_SINK_OFF;
    end else if (blank_r) begin
      sink_r <= `GPWM_SINK_OFF;
    end else begin
      sink_r <= ~lit;
    end
  end

  assign sink_output_n = sink_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule // gpwm_engine
`default_nettype wire

// ### gpwm_consts.vh
// Constants of the grayscale PWM engine: register offsets, field positions, reset values.
// Assumes a 32-bit APB slave with byte addresses; included by its bare name.
// How it works
// - One 16-bit counter steps once per grayscale clock rising edge.
// - Blank set clears the counter and holds it at zero.
// - Spread select zero gives single-pulse PWM, one gives segmented PWM.
// - Total on-time per period equals grayscale value times grayscale clock period.
// - After reset the blank bit reads one.
// - All sinks stay off while blank is one.
// - First edge after release steps counter and lights every non-zero channel.
// - Single-pulse channel stays on while counter is at or below its value.
// - Latch strobe with timing reset set acts as a momentary blank pulse.
// - Auto repeat makes the same pulse at the 65,536th grayscale clock.
// - Counting starts after blank release or a latch strobe under timing reset.
// - A single-pulse channel once off stays off until blank, unless reset or repeat set.
// - Segmented mode splits the 65,536-clock period into 128 segments.
// - No segment is longer than 512 grayscale clocks.
// - Segmented value one lights one clock in the first segment only.
// - Each value step adds one clock, segments in bit-reversed order.
// - Segmented value 128 lights one clock in every segment.
`ifndef GPWM_CONSTS_VH
`define GPWM_CONSTS_VH

// Register byte offsets
`define GPWM_CTRL_OFS 12'h000
`define GPWM_LATCH_OFS 12'h004
`define GPWM_STATUS_OFS 12'h008
`define GPWM_SINK_OFS 12'h00C
`define GPWM_GS_BASE_OFS 12'h040
`define GPWM_GS_LAST_OFS 12'h07C

// Control register fields
`define GPWM_CTRL_BLANK 0
`define GPWM_CTRL_SPREAD 1
`define GPWM_CTRL_TIMING_RESET_BIT 2
`define GPWM_CTRL_REPEAT 3

// Status register fields
`define GPWM_STAT_ACTIVE 16
`define GPWM_STAT_ARMED 17

// Reset values
`define GPWM_CTRL_RST 4'h1
`define GPWM_GS_RST 16'h0000
`define GPWM_CNT_RST 16'h0000
`define GPWM_SINK_OFF 16'hFFFF

// Segment layout: 128 segments of 512 clocks
`define GPWM_SEG_HI 15
`define GPWM_SEG_LO 9
`define GPWM_OFS_HI 8
`define GPWM_LAST_POS 16'hFFFF

`endif

// ### gpwm_sync.v
// Two-flop synchroniser with rising-edge pulse for the grayscale clock pin.
// Assumes the pin runs well below half of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module gpwm_sync (
  input wire clk_sys,
  input wire sys_rst,
  input wire pin_in,
  output wire rise
);
  reg meta_r;
  reg sync_r;
  reg prev_r;

  // First flop feeds only the second
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r;
endmodule // gpwm_sync
`default_nettype wire

// ### gpwm_chan.v
// Per-channel comparator for single-pulse and segmented PWM.
// Assumes pos counts clocks from zero within the display period.
`timescale 1ns/1ps
`default_nettype none
`include "gpwm_consts.vh"
module gpwm_chan (
  input wire [15:0] gs_value,
  input wire [15:0] pos,
  input wire spread_sel,
  input wire active,
  output wire lit
);
  function [6:0] gpwm_rev7;
    input [6:0] v;
    integer i;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        gpwm_rev7[i] = v[6 - i];
      end
    end
  endfunction

  wire [6:0] seg;
  wire [8:0] ofs;
  wire extra;
  wire [8:0] seg_base;
  wire [9:0] seg_on;
  wire conv_on;
  wire es_on;

  assign seg = pos[`GPWM_SEG_HI:`GPWM_SEG_LO];
  assign ofs = pos[`GPWM_OFS_HI:0];
  assign extra = (gpwm_rev7(seg) < gs_value[6:0]);
  assign seg_base = gs_value[15:7];
  assign seg_on = {1'b0, seg_base} + {9'h000, extra};
  assign conv_on = (pos < gs_value);
  assign es_on = ({1'b0, ofs} < seg_on);
  assign lit = active & (spread_sel ? es_on : conv_on);
endmodule // gpwm_chan
`default_nettype wire

// ### gpwm_properties.sv
// Port checker for the grayscale PWM engine.
// Assumes it is bound to the engine top.
`timescale 1ns/1ps
`default_nettype none
module gpwm_properties #(
  parameter int CHANNELS = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic grayscale_clock,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CHANNELS-1:0] sink_output_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic rst_q;
  logic [3:0] gs_age;
  always @(posedge clk_sys) begin
    rst_q <= sys_rst;
    if (sys_rst || grayscale_clock) begin
      gs_age <= 4'h0;
    end else if (gs_age != 4'hF) begin
      gs_age <= gs_age + 4'h1;
    end
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready stood too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_reset_sinks_off: assert property (disable iff (1'b0) rst_q |-> &sink_output_n)
    else $error("sinks on after reset");
  a_err_unmapped: assert property (pready && paddr > 12'h00C && paddr < 12'h040 |-> pslverr)
    else $error("unmapped access not refused");
  a_no_err_mapped: assert property (pready && paddr < 12'h010 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  a_sink_needs_cause: assert property ($changed(sink_output_n) && !$past(sys_rst)
    |-> gs_age < 4'h8 || $past(pready) || $past(pready, 2))
    else $error("sinks changed without cause");
  c_lit: cover property (!(&sink_output_n));
  c_err: cover property (pslverr);
  c_write: cover property (pready && pwrite);
endmodule // gpwm_properties
`default_nettype wire

// ### gpwm_grayscale_clock.sv
// Display controller model: makes grayscale clock pulses on request.
// Clock stands low between bursts; holds each level HALF system cycles.
`timescale 1ns/1ps
`default_nettype none
module gpwm_grayscale_clock #(
  parameter int HALF = 4
) (
  input wire logic clk_sys,
  output logic grayscale_clock
);
  initial grayscale_clock = 1'b0;
  task automatic edges(input int n);
    repeat (n) begin
      repeat (HALF) @(posedge clk_sys);
      grayscale_clock <= 1'b1;
      repeat (HALF) @(posedge clk_sys);
      grayscale_clock <= 1'b0;
    end
    repeat (HALF) @(posedge clk_sys);
  endtask
endmodule // gpwm_grayscale_clock
`default_nettype wire

// ### gpwm_engine_tb_top.sv
// Testbench for the grayscale PWM engine.
// Registers over APB; grayscale clock from the controller model.
`timescale 1ns/1ps
`default_nettype none
module gpwm_engine_tb_top;
  logic clk_sys;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] sink_output_n;
  wire logic grayscale_clock;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] r;
  logic e;
  gpwm_engine #(.CHANNELS(16)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .grayscale_clock(grayscale_clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sink_output_n(sink_output_n));
  gpwm_grayscale_clock g (.clk_sys(clk_sys), .grayscale_clock(grayscale_clock));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next setup never reassigns psel in this time step
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask
  task automatic t_reset;
    rd(12'h000, 32'h1, 32'hF);
    rd(12'h00C, 32'hFFFF, 32'hFFFF);
    rd(12'h008, 32'h0, 32'hFFFF);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_conv;
    wr(12'h040, 32'h2);
    wr(12'h044, 32'h0);
    wr(12'h048, 32'h1);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h0);
    rd(12'h00C, 32'hFFFF, 32'hFFFF);
    g.edges(1);
    rd(12'h00C, 32'hFFFA, 32'hFFFF);
    g.edges(1);
    rd(12'h00C, 32'hFFFE, 32'hFFFF);
    g.edges(1);
    rd(12'h00C, 32'hFFFF, 32'hFFFF);
    rd(12'h008, 32'h3, 32'hFFFF);
    wr(12'h000, 32'h1);
    g.edges(1);
    rd(12'h008, 32'h0, 32'hFFFF);
    rd(12'h00C, 32'hFFFF, 32'hFFFF);
  endtask
  task automatic t_tmg;
    wr(12'h000, 32'h4);
    g.edges(3);
    rd(12'h008, 32'h3, 32'hFFFF);
    wr(12'h004, 32'h0);
    rd(12'h008, 32'h0, 32'hFFFF);
    g.edges(1);
    rd(12'h00C, 32'hFFFA, 32'hFFFF);
  endtask
  task automatic t_seg;
    wr(12'h000, 32'h1);
    wr(12'h040, 32'h81);
    wr(12'h044, 32'h80);
    wr(12'h048, 32'h1);
    wr(12'h000, 32'h3);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h2);
    g.edges(1);
    rd(12'h00C, 32'hFFF8, 32'hFFFF);
    g.edges(1);
    rd(12'h00C, 32'hFFFE, 32'hFFFF);
    g.edges(1);
    rd(12'h00C, 32'hFFFF, 32'hFFFF);
  endtask
  task automatic finish_test;
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    sys_rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h00000000;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_conv();
    t_tmg();
    t_seg();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
endmodule // gpwm_engine_tb_top
bind gpwm_engine gpwm_properties #(.CHANNELS(CHANNELS)) chk_u (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .grayscale_clock(grayscale_clock), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sink_output_n(sink_output_n));
`default_nettype wire
